// *** logic/gpcb_pkg.sv ***
`default_nettype none
package gpcb_pkg;
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] CFG_12_13_ADDR = 8'h1b;
    localparam logic [7:0] CFG_14_15_ADDR = 8'h1c;
    localparam logic [7:0] MODE_0_7_ADDR  = 8'h1d;
    localparam logic [7:0] MODE_8_15_ADDR = 8'h1e;
    localparam logic [7:0] IRQ_STAT_ADDR  = 8'h30;
    localparam logic [7:0] IRQ_CLR_ADDR   = 8'h31;
    localparam logic [7:0] IRQ_EN_ADDR    = 8'h32;
    localparam logic [7:0] REG_RESET      = 8'h00;

    // ------------------------------------------------------------
    // field layout of a two-pin config register
    // ------------------------------------------------------------
    localparam int unsigned LO_FN_LSB   = 0;
    localparam int unsigned LO_POL_BIT  = 2;
    localparam int unsigned LO_WAKE_BIT = 3;
    localparam int unsigned HI_FN_LSB   = 4;
    localparam int unsigned HI_POL_BIT  = 6;
    localparam int unsigned HI_WAKE_BIT = 7;
    // mode bits of pins 12..15 in the upper mode register
    localparam int unsigned MODE_P12_BIT = 4;
    localparam int unsigned MODE_P13_BIT = 5;
    localparam int unsigned MODE_P14_BIT = 6;
    localparam int unsigned MODE_P15_BIT = 7;
    // sequencer-driven pins in the lower mode register
    localparam int unsigned SEQ_P3_BIT = 3;
    localparam int unsigned SEQ_P4_BIT = 4;
    localparam int unsigned SEQ_P6_BIT = 6;
    localparam int unsigned SEQ_P7_BIT = 7;

    // ------------------------------------------------------------
    // function codes
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        FN_SPECIAL = 2'h0,
        FN_INPUT   = 2'h1,
        FN_ALT     = 2'h2,
        FN_REG_OUT = 2'h3
    } gpcb_fn_t;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned DEB_TIME_NS   = 10000;
    localparam int unsigned DEB_CYCLES    =
        (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DEB_CNT_W     = 16;
endpackage
`default_nettype wire

// *** logic/gpcb_deb_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface gpcb_deb_if;
    logic [3:0] raw;    // active-level inputs of pins 12..15
    logic [3:0] en;     // debounce enables
    logic [3:0] clean;  // filtered levels
    modport user (output raw, output en, input clean);
    modport filt (input raw, input en, output clean);
endinterface // gpcb_deb_if
`default_nettype wire

// *** logic/gpcb_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpcb_debounce
#(
    parameter logic [15:0] CYC = 16'(gpcb_pkg::DEB_CYCLES)
)
(
    input  wire logic  clk,   // system clock
    input  wire logic  rst_b, // async reset, active low
    input  wire logic  ce,    // clock enable
    gpcb_deb_if.filt   dbus   // raw in, clean out
);
    logic [gpcb_pkg::DEB_CNT_W-1:0] cnt_r [4];

    // with its enable set, a level is taken only after it held CYC cycles, so a bounce
    // restarts the count; the cost is CYC-1 cycles of added latency
    // one process owns the whole clean vector, so no bit has two drivers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 4; i++)
            begin
                cnt_r[i] <= '0;
            end
            dbus.clean <= 4'h0;
        end
        else if (ce)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (!dbus.en[i] || dbus.raw[i] == dbus.clean[i])
                begin
                    cnt_r[i]      <= '0;
                    dbus.clean[i] <= dbus.raw[i];
                end
                else if (cnt_r[i] >= CYC - 16'h0001)
                begin
                    cnt_r[i]      <= '0;
                    dbus.clean[i] <= dbus.raw[i];
                end
                else
                begin
                    cnt_r[i] <= cnt_r[i] + 16'h0001;
                end
            end
        end
    end

    chk_deb_bypass : assert property (@(posedge clk) disable iff (!rst_b)
        ce && !dbus.en[0] |=> dbus.clean[0] == $past(dbus.raw[0]))
        else $error("undebounced input did not pass straight");

    chk_deb_holdoff : assert property (@(posedge clk) disable iff (!rst_b)
        ce && dbus.en[1] && dbus.raw[1] != dbus.clean[1] && cnt_r[1] == '0
        |=> dbus.clean[1] == $past(dbus.clean[1]))
        else $error("debounced input changed at once");
endmodule // gpcb_debounce
`default_nettype wire

// *** logic/gpcb_top.sv ***
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module gpcb_top
#(
    parameter logic [15:0] DEB_CYC = 16'(gpcb_pkg::DEB_CYCLES)
)
(
    input  wire logic       clk,                    // 50 MHz clock
    input  wire logic       rst_b,                  // async reset, active low
    input  wire logic       ce,                     // clock enable
    input  wire logic [7:0] addr,                   // register address
    input  wire logic [7:0] wdata,                  // write data
    input  wire logic       wr,                     // write strobe
    input  wire logic       rd,                     // read strobe
    output logic      [7:0] rdata_o,                // read data, cycle after rd
    input  wire logic [3:0] pin_in,                 // pad levels, pins 12..15
    output logic      [3:0] pin_out_o,              // pad output levels
    output logic      [3:0] pin_oe_o,               // pad output enables
    output logic      [3:0] bank_b_o,               // 1: io_supply_bank_b
    output logic      [3:0] pin_active_o,           // filtered active states
    input  wire logic       supply_fault_indicator, // 1: supply fault
    input  wire logic       vsys_monitor_state,     // 1: monitor asserted
    input  wire logic       feedback_ready_state,   // 1: feedback asserted
    input  wire logic [1:0] blink_req,              // blink phase, pins 14, 15
    input  wire logic       hs_data_low,            // two-wire data pull
    input  wire logic       hs_clk_low,             // two-wire clock pull
    output logic            hs_port_en_o,           // two-wire port selected
    output logic            hs_data_in_o,           // two-wire data level
    output logic            hs_clk_in_o,            // two-wire clock level
    output logic            thresh_core_o,          // core_supply thresholds
    input  wire logic [3:0] seq_req,                // sequencer, pins 3,4,6,7
    output logic      [3:0] seq_out_o,              // sequencer pin levels
    output logic      [7:0] mode_lo_o,              // pins 0..7 mode bits
    output logic            wake_o,                 // wakeup pulse
    output logic            irq_o                   // level interrupt
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // level of an indicator whose polarity bit is 1 for active high
    function automatic logic ind(input logic state, input logic pol);
        return pol ? state : ~state;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] cfg_a_r;    // pins 12, 13
    logic [7:0] cfg_b_r;    // pins 14, 15
    logic [7:0] mode_lo_r;  // pins 0..7
    logic [7:0] mode_hi_r;  // pins 8..15
    logic [3:0] irq_stat_r;
    logic [3:0] irq_en_r;
    logic [3:0] irq_stat_nxt;
    logic [3:0] wake_hit;
    logic [3:0] clr_mask;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_a_r   <= gpcb_pkg::REG_RESET;
            cfg_b_r   <= gpcb_pkg::REG_RESET;
            mode_lo_r <= gpcb_pkg::REG_RESET;
            mode_hi_r <= gpcb_pkg::REG_RESET;
            irq_en_r  <= 4'h0;
        end
        else if (ce && wr)
        begin
            if (hit(addr, gpcb_pkg::CFG_12_13_ADDR))
                cfg_a_r <= wdata;
            else if (hit(addr, gpcb_pkg::CFG_14_15_ADDR))
                cfg_b_r <= wdata;
            else if (hit(addr, gpcb_pkg::MODE_0_7_ADDR))
                mode_lo_r <= wdata;
            else if (hit(addr, gpcb_pkg::MODE_8_15_ADDR))
                mode_hi_r <= wdata;
            else if (hit(addr, gpcb_pkg::IRQ_EN_ADDR))
                irq_en_r <= wdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    gpcb_pkg::gpcb_fn_t fn12, fn13, fn14, fn15;
    logic [3:0] pol;
    logic [3:0] inhibit;
    logic [3:0] mbit;
    logic       hs_mode;

    assign fn12 = gpcb_pkg::gpcb_fn_t'(cfg_a_r[gpcb_pkg::LO_FN_LSB +: 2]);
    assign fn13 = gpcb_pkg::gpcb_fn_t'(cfg_a_r[gpcb_pkg::HI_FN_LSB +: 2]);
    assign fn14 = gpcb_pkg::gpcb_fn_t'(cfg_b_r[gpcb_pkg::LO_FN_LSB +: 2]);
    assign fn15 = gpcb_pkg::gpcb_fn_t'(cfg_b_r[gpcb_pkg::HI_FN_LSB +: 2]);
    assign pol  = {cfg_b_r[gpcb_pkg::HI_POL_BIT], cfg_b_r[gpcb_pkg::LO_POL_BIT],
                   cfg_a_r[gpcb_pkg::HI_POL_BIT], cfg_a_r[gpcb_pkg::LO_POL_BIT]};
    assign inhibit = {cfg_b_r[gpcb_pkg::HI_WAKE_BIT], cfg_b_r[gpcb_pkg::LO_WAKE_BIT],
                      cfg_a_r[gpcb_pkg::HI_WAKE_BIT], cfg_a_r[gpcb_pkg::LO_WAKE_BIT]};
    assign mbit = {mode_hi_r[gpcb_pkg::MODE_P15_BIT], mode_hi_r[gpcb_pkg::MODE_P14_BIT],
                   mode_hi_r[gpcb_pkg::MODE_P13_BIT], mode_hi_r[gpcb_pkg::MODE_P12_BIT]};
    // pin 15 is only a clock while pin 14 has claimed the port
    assign hs_mode = (fn14 == gpcb_pkg::FN_ALT);

    // ------------------------------------------------------------
    // input path and wakeup
    // ------------------------------------------------------------
    gpcb_deb_if dbus ();
    logic [3:0] act_prev_r;
    logic [3:0] is_input;

    assign dbus.raw = pol ^ ~pin_in;
    assign dbus.en  = mbit;
    assign is_input = {fn15 == gpcb_pkg::FN_INPUT, fn14 == gpcb_pkg::FN_INPUT,
                       fn13 == gpcb_pkg::FN_INPUT, fn12 == gpcb_pkg::FN_INPUT};
    // a polarity flip can look like an edge; software should set the
    // inhibit bit while it reconfigures a pin
    assign wake_hit = dbus.clean & ~act_prev_r & is_input & ~inhibit;

    gpcb_debounce #(.CYC(DEB_CYC)) u_deb
    (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .dbus  (dbus)
    );

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            act_prev_r   <= 4'h0;
            pin_active_o <= 4'h0;
            wake_o       <= 1'b0;
        end
        else if (ce)
        begin
            act_prev_r   <= dbus.clean;
            pin_active_o <= dbus.clean;
            wake_o       <= |wake_hit;
        end
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    assign clr_mask = (wr && hit(addr, gpcb_pkg::IRQ_CLR_ADDR)) ? wdata[3:0] : 4'h0;
    // a new wake event wins over a clear in the same cycle
    assign irq_stat_nxt = (irq_stat_r & ~clr_mask) | wake_hit;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_stat_r <= 4'h0;
            irq_o      <= 1'b0;
        end
        else if (ce)
        begin
            irq_stat_r <= irq_stat_nxt;
            irq_o      <= |(irq_stat_nxt & irq_en_r);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_o <= 8'h00;
        else if (ce)
        begin
            if (!rd)
                rdata_o <= 8'h00;
            else if (hit(addr, gpcb_pkg::CFG_12_13_ADDR))
                rdata_o <= cfg_a_r;
            else if (hit(addr, gpcb_pkg::CFG_14_15_ADDR))
                rdata_o <= cfg_b_r;
            else if (hit(addr, gpcb_pkg::MODE_0_7_ADDR))
                rdata_o <= mode_lo_r;
            else if (hit(addr, gpcb_pkg::MODE_8_15_ADDR))
                rdata_o <= mode_hi_r;
            else if (hit(addr, gpcb_pkg::IRQ_STAT_ADDR))
                rdata_o <= {4'h0, irq_stat_r};
            else if (hit(addr, gpcb_pkg::IRQ_EN_ADDR))
                rdata_o <= {4'h0, irq_en_r};
            else
                rdata_o <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic [3:0] out_nxt;
    logic [3:0] oe_nxt;

    always_comb
    begin
        out_nxt = 4'h0;
        oe_nxt  = 4'h0;
        case (fn12)
            gpcb_pkg::FN_SPECIAL:
            begin
                out_nxt[0] = ind(supply_fault_indicator, mbit[0]);
                oe_nxt[0]  = 1'b1;
            end
            gpcb_pkg::FN_ALT:
            begin
                out_nxt[0] = ind(vsys_monitor_state, mbit[0]);
                oe_nxt[0]  = 1'b1;
            end
            gpcb_pkg::FN_REG_OUT:
            begin
                out_nxt[0] = mbit[0];
                oe_nxt[0]  = 1'b1;
            end
            default: ;
        endcase
        case (fn13)
            gpcb_pkg::FN_SPECIAL:
            begin
                out_nxt[1] = ind(feedback_ready_state, mbit[1]);
                oe_nxt[1]  = 1'b1;
            end
            gpcb_pkg::FN_ALT:
                oe_nxt[1] = ~ind(feedback_ready_state, mbit[1]);
            gpcb_pkg::FN_REG_OUT:
            begin
                out_nxt[1] = mbit[1];
                oe_nxt[1]  = 1'b1;
            end
            default: ;
        endcase
        case (fn14)
            gpcb_pkg::FN_SPECIAL:
                oe_nxt[2] = ~ind(blink_req[0], ~mbit[2]);
            gpcb_pkg::FN_ALT:
                oe_nxt[2] = hs_data_low;
            gpcb_pkg::FN_REG_OUT:
            begin
                out_nxt[2] = mbit[2];
                oe_nxt[2]  = 1'b1;
            end
            default: ;
        endcase
        case (fn15)
            gpcb_pkg::FN_SPECIAL:
                oe_nxt[3] = ~ind(blink_req[1], ~mbit[3]);
            gpcb_pkg::FN_ALT:
                oe_nxt[3] = hs_mode & hs_clk_low;
            gpcb_pkg::FN_REG_OUT:
                oe_nxt[3] = ~mbit[3];
            default: ;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_out_o <= 4'h0;
            pin_oe_o  <= 4'h0;
            bank_b_o  <= 4'h0;
        end
        else if (ce)
        begin
            pin_out_o <= out_nxt;
            pin_oe_o  <= oe_nxt;
            bank_b_o  <= pol;
        end
    end

    // ------------------------------------------------------------
    // two-wire port and pins 0..7
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hs_port_en_o  <= 1'b0;
            hs_data_in_o  <= 1'b1;
            hs_clk_in_o   <= 1'b1;
            thresh_core_o <= 1'b0;
            seq_out_o     <= 4'h0;
            mode_lo_o     <= 8'h00;
        end
        else if (ce)
        begin
            hs_port_en_o  <= hs_mode;
            hs_data_in_o  <= pin_in[2];
            hs_clk_in_o   <= pin_in[3];
            thresh_core_o <= hs_mode;
            seq_out_o[0]  <= ind(seq_req[0], mode_lo_r[gpcb_pkg::SEQ_P3_BIT]);
            seq_out_o[1]  <= ind(seq_req[1], mode_lo_r[gpcb_pkg::SEQ_P4_BIT]);
            seq_out_o[2]  <= ind(seq_req[2], mode_lo_r[gpcb_pkg::SEQ_P6_BIT]);
            seq_out_o[3]  <= ind(seq_req[3], mode_lo_r[gpcb_pkg::SEQ_P7_BIT]);
            mode_lo_o     <= mode_lo_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_wr_cfg_a;
        ce && wr && addr == 8'h1b;
    endsequence
    sequence s_rd_cfg_a;
        ce && rd && addr == 8'h1b && !wr;
    endsequence

    chk_wake_sets_flag : assert property (
        ce && wake_hit[0] |=> irq_stat_r[0] && wake_o)
        else $error("wake event lost");
    chk_wake_inhibit : assert property (
        ce && wake_hit == 4'h0 && irq_stat_r == 4'h0 && !wr |=> !wake_o && irq_stat_r == 4'h0)
        else $error("wake without enabled edge");
    chk_bank_select : assert property (
        s_wr_cfg_a ##1 ce[*2] |=> bank_b_o[0] == $past(wdata[2], 3))
        else $error("bank select not following polarity");
    chk_cfg_readback : assert property (
        s_wr_cfg_a ##1 s_rd_cfg_a |=> rdata_o == $past(wdata, 2))
        else $error("config readback mismatch");
    chk_fault_drive : assert property (
        ce && fn12 == gpcb_pkg::FN_SPECIAL
        |=> pin_oe_o[0] && pin_out_o[0] == ($past(supply_fault_indicator) ~^ $past(mbit[0])))
        else $error("fault indicator level wrong");
    chk_fb_open_drain : assert property (
        ce && fn13 == gpcb_pkg::FN_ALT |=> !pin_out_o[1])
        else $error("open-drain pin driven high");
    chk_gpo_level : assert property (
        ce && fn12 == gpcb_pkg::FN_REG_OUT |=> pin_out_o[0] == $past(mode_hi_r[4]))
        else $error("register output level wrong");
    chk_clk_pin : assert property (
        ce && fn15 == gpcb_pkg::FN_ALT && !hs_mode |=> !pin_oe_o[3])
        else $error("clock pin driven without data pin");
    chk_core_thresh : assert property (
        ce && hs_mode |=> thresh_core_o && hs_port_en_o)
        else $error("two-wire thresholds not on core supply");
    chk_seq_pol : assert property (
        ce && !mode_lo_r[3] |=> seq_out_o[0] == !$past(seq_req[0]))
        else $error("sequencer polarity wrong");
    chk_blink_pol : assert property (
        ce && fn14 == gpcb_pkg::FN_SPECIAL && !mbit[2] && blink_req[0] |=> !pin_oe_o[2])
        else $error("blink polarity wrong");
endmodule // gpcb_top
`default_nettype wire

// *** sim/gpcb_pad_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// pads of pins 12..15 with the board around them
// ------------------------------------------------------------
module gpcb_pad_model
(
    input  wire logic [3:0] pad_out, // level driven by the block
    input  wire logic [3:0] pad_oe,  // block drives the pad
    input  wire logic [3:0] ext_en,  // outside circuit drives the pad
    input  wire logic [3:0] ext_val, // level of the outside circuit
    output logic      [3:0] pad_lvl  // resolved pad level
);
    // a pad that neither side drives sits on its board pull-up, never on a stale value
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            pad_lvl[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule // gpcb_pad_model
`default_nettype wire

// *** sim/gpio_pin_config_bank_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_config_bank_test;
    logic       clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, mode_lo, r;
    logic [3:0] ext_en = 4'h0, ext_val = 4'h0, seq_req = 4'h0, pad, pout, poe, bank, act, sq;
    logic [1:0] blink = 2'h0;
    logic       hs_clk_low = 1'b1, hs_data_low = 1'b0, ce = 1'b1;
    logic       hs_en, hs_d, hs_c, thr, wake, irq;
    logic [7:0] exp_q[$];
    int         num_errors = 0, total_checks = 0, wake_cnt = 0, w0;
    logic [7:0] cf[6] = '{8'h00, 8'h00, 8'h22, 8'h33, 8'h33, 8'h44};
    logic [7:0] md[6] = '{8'h00, 8'h30, 8'h30, 8'h10, 8'h20, 8'h00};
    logic [1:0] eo[6] = '{2'h0, 2'h3, 2'h0, 2'h1, 2'h2, 2'h0};
    logic [1:0] ee[6] = '{2'h3, 2'h3, 2'h1, 2'h3, 2'h3, 2'h3};

    always #10 clk = ~clk;

    gpcb_pad_model pads_u (.pad_out(pout), .pad_oe(poe), .ext_en(ext_en), .ext_val(ext_val),
        .pad_lvl(pad));

    gpcb_top #(.DEB_CYC(16'h0004)) dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_o(rdata), .pin_in(pad), .pin_out_o(pout),
        .pin_oe_o(poe), .bank_b_o(bank), .pin_active_o(act), .supply_fault_indicator(1'b1),
        .vsys_monitor_state(1'b0), .feedback_ready_state(1'b1), .blink_req(blink),
        .hs_data_low(hs_data_low), .hs_clk_low(hs_clk_low), .hs_port_en_o(hs_en),
        .hs_data_in_o(hs_d), .hs_clk_in_o(hs_c), .thresh_core_o(thr), .seq_req(seq_req),
        .seq_out_o(sq), .mode_lo_o(mode_lo), .wake_o(wake), .irq_o(irq));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b1;
        exp_q.push_back(d);
        @(posedge clk);
        rd    <= 1'b0;
    endtask

    // pad stimulus changes right after a rising edge
    task automatic pin_drv(input logic [3:0] en, input logic [3:0] val);
        @(posedge clk);
        ext_en  <= en;
        ext_val <= val;
    endtask

    // pins follow config two edges after the write
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // read-data watcher: data stands only in the cycle after rd
    // ------------------------------------------------------------
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) if (wake === 1'b1) wake_cnt++;
    always @(negedge clk)
    begin
        if (rd_seen)
        begin
            if (exp_q.size() == 0)
                check(rdata, 8'hxx);
            else
                check(rdata, exp_q.pop_front());
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(25500));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        seq_req <= 4'($urandom);
        rd_reg(8'h1b, 8'h00);
        rd_reg(8'h1c, 8'h00);
        rd_reg(8'h1d, 8'h00);
        rd_reg(8'h55, 8'h00);
        r = 8'($urandom);
        wr_reg(8'h1d, r);
        rd_reg(8'h1d, r);
        settle(2);
        check(mode_lo, r);
        check({4'h0, sq}, {4'h0, ~(seq_req ^ {r[7], r[6], r[4], r[3]})});
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(8'h1e, md[i]);
            wr_rd(8'h1b, cf[i]);
            settle(3);
            check({6'h0, pout[1:0]}, {6'h0, eo[i]});
            check({6'h0, poe[1:0]}, {6'h0, ee[i]});
            check({6'h0, bank[1:0]}, {6'h0, cf[i][6], cf[i][2]});
        end
        wr_reg(8'h1c, 8'h22);
        settle(3);
        check({6'h0, hs_en, thr}, 8'h03);
        check({6'h0, poe[3:2]}, 8'h02);
        check({6'h0, hs_c, hs_d}, 8'h01);
        @(posedge clk) hs_data_low <= 1'b1;
        settle(2);
        check({7'h0, poe[2]}, 8'h01);
        // clock code without the data pin claiming the port leaves pin 15 released
        wr_reg(8'h1c, 8'h20);
        settle(3);
        check({7'h0, poe[3]}, 8'h00);
        @(posedge clk) blink <= 2'h1;
        wr_reg(8'h1e, 8'h00);
        wr_reg(8'h1c, 8'h30);
        settle(3);
        check({6'h0, poe[3:2]}, 8'h02);
        wr_reg(8'h1e, 8'hc0);
        settle(3);
        check({6'h0, poe[3:2]}, 8'h01);
        wr_reg(8'h1c, 8'h03);
        settle(3);
        check({6'h0, pout[2], poe[2]}, 8'h03);
        pin_drv(4'h1, 4'h0);
        wr_reg(8'h1e, 8'h00);
        wr_reg(8'h32, 8'h01);
        wr_reg(8'h1b, 8'h05);
        settle(3);
        w0 = wake_cnt;
        pin_drv(4'h1, 4'h1);
        settle(4);
        check(8'(wake_cnt - w0), 8'h01);
        check({6'h0, irq, act[0]}, 8'h03);
        rd_reg(8'h30, 8'h01);
        wr_reg(8'h31, 8'h01);
        settle(2);
        check({7'h0, irq}, 8'h00);
        pin_drv(4'h1, 4'h0);
        wr_reg(8'h1b, 8'h0d);
        settle(3);
        w0 = wake_cnt;
        pin_drv(4'h1, 4'h1);
        settle(4);
        check(8'(wake_cnt - w0), 8'h00);
        rd_reg(8'h30, 8'h00);
        // debounced input: a two-cycle glitch must not pass
        pin_drv(4'h1, 4'h0);
        wr_reg(8'h1e, 8'h10);
        wr_reg(8'h1b, 8'h05);
        settle(10);
        w0 = wake_cnt;
        pin_drv(4'h1, 4'h1);
        settle(1);
        pin_drv(4'h1, 4'h0);
        settle(8);
        check({7'h0, act[0]}, 8'h00);
        pin_drv(4'h1, 4'h1);
        settle(10);
        check({7'h0, act[0]}, 8'h01);
        check(8'(wake_cnt - w0), 8'h01);
        // a write while the clock enable is low must leave the register alone
        @(posedge clk) ce <= 1'b0;
        wr_reg(8'h1d, ~r);
        ce <= 1'b1;
        rd_reg(8'h1d, r);
        settle(2);
        conclude();
    end
endmodule // gpio_pin_config_bank_test
`default_nettype wire
